/* sdcrb_defines.svh */
/*
 * Register offsets, field positions, reset values and frame figures of the
 * shadowed dual channel register bank.
 * Assumes inclusion by its bare name from the package and the design file.
 */
`ifndef SDCRB_DEFINES_SVH
`define SDCRB_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SDCRB_ADDR_CFG       13'h0000
`define SDCRB_ADDR_ID        13'h0001
`define SDCRB_ADDR_GRADE     13'h0002
`define SDCRB_ADDR_CHAN      13'h0005
`define SDCRB_ADDR_COMMIT    13'h00ff
`define SDCRB_ADDR_SHD_LO    13'h0008
`define SDCRB_ADDR_SHD_HI    13'h0020
`define SDCRB_ADDR_SHD_XTRA  13'h003a
`define SDCRB_ADDR_GCLOCK    13'h0009
`define SDCRB_ADDR_CLKDIV    13'h000b

// ****************************************************************
// Shadow storage layout
// ****************************************************************
`define SDCRB_SHD_COUNT      26
`define SDCRB_SHD_XTRA_IDX   5'd25
`define SDCRB_SHD_GCLOCK_DEF 8'h01

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SDCRB_CFG_RESET      8'h18
`define SDCRB_CFG_LSB_HI     6
`define SDCRB_CFG_LSB_LO     1
`define SDCRB_CFG_SRST_HI    5
`define SDCRB_CFG_SRST_LO    2
`define SDCRB_CHAN_RESET     8'h03
`define SDCRB_CHAN_A         0
`define SDCRB_CHAN_B         1
`define SDCRB_COMMIT_BIT     0
`define SDCRB_GRADE_LO       4

// ****************************************************************
// Frame figures
// ****************************************************************
`define SDCRB_INSTR_BITS     5'd16
`define SDCRB_INSTR_LAST     5'd15
`define SDCRB_FRAME_LAST     5'd23
`define SDCRB_READ_BIT       15
`define SDCRB_ADDR_MSB       12

`endif

/* sdcrb_pkg.sv */
/*
 * Types shared by the shadowed dual channel register bank.
 * Assumes sdcrb_defines.svh is on the include path.
 */
`include "sdcrb_defines.svh"

package sdcrb_pkg;

  typedef logic [`SDCRB_SHD_COUNT-1:0][7:0] sdcrb_bank_type;

  typedef struct packed {
    sdcrb_bank_type chan_a;
    sdcrb_bank_type chan_b;
  } sdcrb_pair_type;

  typedef struct packed {
    logic        read;
    logic [1:0]  length;
    logic [12:0] addr;
  } sdcrb_instr_type;

endpackage

/* sdcrb_bank.sv */
/*
 * Serial configuration port and shadowed register bank of a dual channel
 * converter: serial logic on the serial clock, active copies on i_sys_clk.
 * Assumes serial_select_low, serial clock and the data pin come straight
 * from the pins, and that the data pin is resolved outside from the enable.
 */
// Contract
// - Writes to 0x08..0x20 and 0x3A land in shadows, not in active copies.
// - Writing one to 0xff copies every shadow into active copies at once.
// - The commit bit clears itself once the copy has happened.
// - Local registers exist per channel, steered by channel select bits.
// - With both select bits set, a local write updates both channels.
// - With both select bits set, a local read returns channel A.
// - Global registers ignore the channel select bits on read and write.
// - Frame is a 16 bit instruction then 8 bit data words.
// - Port shifts most significant bit first until bit order changes.
// - Reset loads registers with their default values.
`include "sdcrb_defines.svh"

module sdcrb_bank #(
  parameter logic [7:0] DEVICE_IDENTIFIER    = 8'h5a,  // Arbitrary value
  parameter logic [1:0] SPEED_CODE = 2'b00
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_serial_clk,
  input  wire logic                    i_serial_select_low,
  input  wire logic                    i_sdio,
  output logic                         o_sdio,
  output logic                         o_sdio_oe_n,
  output sdcrb_pkg::sdcrb_pair_type    o_active,
  output logic                         o_commit_pulse
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic is_shadowed(input logic [12:0] a);
    is_shadowed = (a >= `SDCRB_ADDR_SHD_LO && a <= `SDCRB_ADDR_SHD_HI) ||
                  (a == `SDCRB_ADDR_SHD_XTRA);
  endfunction

  function automatic logic [4:0] shd_index(input logic [12:0] a);
    logic [12:0] d;
    d = a - `SDCRB_ADDR_SHD_LO;
    shd_index = (a == `SDCRB_ADDR_SHD_XTRA) ? `SDCRB_SHD_XTRA_IDX : d[4:0];
  endfunction

  function automatic logic is_global(input logic [12:0] a);
    is_global = (a == `SDCRB_ADDR_GCLOCK) || (a == `SDCRB_ADDR_CLKDIV);
  endfunction

  function automatic sdcrb_pkg::sdcrb_bank_type bank_default();
    sdcrb_pkg::sdcrb_bank_type b;
    b = '0;
    b[shd_index(`SDCRB_ADDR_GCLOCK)] = `SDCRB_SHD_GCLOCK_DEF;
    bank_default = b;
  endfunction

  // ****************************************************************
  // Reset image of the shadow and active banks
  // ****************************************************************
  // Held as a constant so the asynchronous reset branches load no logic
  localparam sdcrb_pkg::sdcrb_bank_type BANK_RESET = bank_default();

  // Shift one bit into a word in the selected order
  function automatic logic [15:0] shift_in(input logic [15:0] s, input logic d,
                                           input logic lsb, input logic wide);
    if (!lsb)
      shift_in = {s[14:0], d};
    else if (wide)
      shift_in = {d, s[15:1]};
    else
      shift_in = {8'h00, d, s[7:1]};
  endfunction

  // ****************************************************************
  // Serial clock domain: frame state
  // ****************************************************************
  logic                      frame_rst_n;
  logic [4:0]                bit_cnt, next_bit_cnt;
  logic [15:0]               shreg, next_shreg;
  sdcrb_pkg::sdcrb_instr_type instr, next_instr;
  logic [7:0]                tx_byte, next_tx_byte;
  logic                      drive_bit;
  logic                      drive_en;

  // Serial_select_low high ends the frame at once, sclk may be stopped
  assign frame_rst_n = i_resetn & ~i_serial_select_low;

  // ****************************************************************
  // Serial clock domain: registers
  // ****************************************************************
  logic [7:0]                cfg, next_cfg;
  logic [7:0]                chan, next_chan;
  sdcrb_pkg::sdcrb_pair_type shadow, next_shadow;
  logic                      commit_req, next_commit_req;
  logic                      ack_meta, ack_sync;
  logic                      ack_ret;
  logic                      pending;

  logic                      lsb_first;
  logic [15:0]               full_word;
  logic [7:0]                rx_byte;
  logic                      byte_done;
  logic                      wr_strobe;
  logic [12:0]               cur_addr;
  logic [4:0]                idx;
  logic                      soft_rst;
  logic                      cfg_order;

  assign lsb_first = cfg[`SDCRB_CFG_LSB_HI] | cfg[`SDCRB_CFG_LSB_LO];
  assign pending   = commit_req ^ ack_sync;
  assign full_word = shift_in(shreg, i_sdio, lsb_first, bit_cnt < `SDCRB_INSTR_BITS);
  assign rx_byte   = full_word[7:0];
  // Either mirrored bit selects the order
  assign cfg_order = rx_byte[`SDCRB_CFG_LSB_HI] | rx_byte[`SDCRB_CFG_LSB_LO];
  assign byte_done = (bit_cnt == `SDCRB_FRAME_LAST);
  assign cur_addr  = instr.addr;
  assign idx       = shd_index(cur_addr);
  assign wr_strobe = byte_done && !instr.read;

  function automatic logic [7:0] read_value(input logic [12:0] a);
    logic [4:0] k;
    k = shd_index(a);
    read_value = 8'h00;
    unique case (a)
      `SDCRB_ADDR_CFG:    read_value = cfg;
      `SDCRB_ADDR_ID:     read_value = DEVICE_IDENTIFIER;
      `SDCRB_ADDR_GRADE:  read_value = {2'b00, SPEED_CODE, 4'h0};
      `SDCRB_ADDR_CHAN:   read_value = chan;
      `SDCRB_ADDR_COMMIT: read_value = {7'h00, pending};
      default: begin
        if (is_shadowed(a)) begin
          // Channel A whenever A is selected, B is not selected, or the bit is global
          if (chan[`SDCRB_CHAN_A] || !chan[`SDCRB_CHAN_B] || is_global(a))
            read_value = shadow.chan_a[k];
          else
            read_value = shadow.chan_b[k];
        end
      end
    endcase
  endfunction

  // ****************************************************************
  // Frame next state
  // ****************************************************************
  always_comb begin
    next_bit_cnt = byte_done ? `SDCRB_INSTR_BITS : bit_cnt + 5'd1;
    next_shreg   = full_word;
    next_instr   = instr;
    next_tx_byte = tx_byte;
    if (bit_cnt == `SDCRB_INSTR_LAST) begin
      next_instr   = full_word;
      next_shreg   = '0;
      next_tx_byte = read_value(full_word[`SDCRB_ADDR_MSB:0]);
    end else if (byte_done) begin
      // Streaming walks to the next address
      next_instr.addr = instr.addr + 13'h0001;
      next_shreg      = '0;
      next_tx_byte    = read_value(instr.addr + 13'h0001);
    end
  end

  always_ff @(posedge i_serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 5'd0;
      shreg   <= 16'h0000;
      instr   <= '0;
      tx_byte <= 8'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      instr   <= next_instr;
      tx_byte <= next_tx_byte;
    end
  end

  // ****************************************************************
  // Read data launch on the falling edge
  // ****************************************************************
  logic [2:0] bit_pos;
  logic       next_drive_bit;
  logic       next_drive_en;

  always_comb begin
    bit_pos        = bit_cnt[2:0];
    next_drive_en  = instr.read && (bit_cnt >= `SDCRB_INSTR_BITS);
    next_drive_bit = lsb_first ? tx_byte[bit_pos] : tx_byte[3'd7 - bit_pos];
  end

  always_ff @(negedge i_serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      drive_bit <= 1'b0;
      drive_en  <= 1'b0;
    end else begin
      drive_bit <= next_drive_bit;
      drive_en  <= next_drive_en;
    end
  end

  assign o_sdio      = drive_bit;
  assign o_sdio_oe_n = ~drive_en;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    next_cfg        = cfg;
    next_chan       = chan;
    next_shadow     = shadow;
    next_commit_req = commit_req;
    soft_rst        = 1'b0;
    if (wr_strobe) begin
      unique case (cur_addr)
        `SDCRB_ADDR_CFG: begin
          // Mirrored so either shift order decodes alike
          next_cfg = {1'b0, cfg_order, 1'b0, 2'b11, 1'b0, cfg_order, 1'b0};
          soft_rst = rx_byte[`SDCRB_CFG_SRST_HI] | rx_byte[`SDCRB_CFG_SRST_LO];
        end
        `SDCRB_ADDR_CHAN: next_chan = {6'h00, rx_byte[1:0]};
        `SDCRB_ADDR_COMMIT: begin
          if (rx_byte[`SDCRB_COMMIT_BIT] && !pending)
            next_commit_req = ~commit_req;
        end
        default: begin
          // Held off while a copy is in flight, shadows must stay stable
          if (is_shadowed(cur_addr) && !pending) begin
            if (chan[`SDCRB_CHAN_A] || is_global(cur_addr))
              next_shadow.chan_a[idx] = rx_byte;
            if (chan[`SDCRB_CHAN_B] || is_global(cur_addr))
              next_shadow.chan_b[idx] = rx_byte;
          end
        end
      endcase
    end
    if (soft_rst) begin
      // Soft reset restores defaults and reads back cleared
      next_cfg    = `SDCRB_CFG_RESET;
      next_chan   = `SDCRB_CHAN_RESET;
      // Limitation: a soft reset during a pending copy keeps the shadows
      if (!pending) begin
        next_shadow.chan_a = bank_default();
        next_shadow.chan_b = bank_default();
      end
    end
  end

  always_ff @(posedge i_serial_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg        <= `SDCRB_CFG_RESET;
      chan       <= `SDCRB_CHAN_RESET;
      shadow     <= {BANK_RESET, BANK_RESET};
      commit_req <= 1'b0;
      ack_meta   <= 1'b0;
      ack_sync   <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      chan       <= next_chan;
      shadow     <= next_shadow;
      commit_req <= next_commit_req;
      ack_meta   <= ack_ret;
      ack_sync   <= ack_meta;
    end
  end

  // ****************************************************************
  // System clock domain: commit handshake and active copies
  // ****************************************************************
  logic                      req_meta, req_sync;
  logic                      next_ack_ret;
  logic                      commit_now;
  sdcrb_pkg::sdcrb_pair_type active, next_active;

  // Shadows are frozen from request until the ack returns
  assign commit_now = req_sync ^ ack_ret;

  // Ack trails the request by one cycle, so commit_now lasts one cycle
  always_comb begin
    next_ack_ret = req_sync;
    next_active  = commit_now ? shadow : active;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_meta       <= 1'b0;
      req_sync       <= 1'b0;
      ack_ret        <= 1'b0;
      active         <= {BANK_RESET, BANK_RESET};
      o_commit_pulse <= 1'b0;
    end else begin
      req_meta       <= commit_req;
      req_sync       <= req_meta;
      ack_ret        <= next_ack_ret;
      active         <= next_active;
      o_commit_pulse <= commit_now;
    end
  end

  assign o_active = active;

endmodule

/* sdcrb_bank_sva.sv */
/* Checker for the shadowed register bank ports.
   Assumes it is bound to every sdcrb_bank instance. */
module sdcrb_bank_chk (
  input wire logic                      i_sys_clk,
  input wire logic                      i_resetn,
  input wire logic                      i_serial_clk,
  input wire logic                      i_serial_select_low,
  input wire logic                      i_sdio,
  input wire logic                      o_sdio,
  input wire logic                      o_sdio_oe_n,
  input wire sdcrb_pkg::sdcrb_pair_type o_active,
  input wire logic                      o_commit_pulse
);
  // ********
  // Rising edges seen in the current frame, saturating
  // ********
  logic [4:0] bits;
  logic [4:0] next_bits;
  always_comb next_bits = (bits == 5'h10) ? bits : bits + 5'h01;
  always_ff @(posedge i_serial_clk or posedge i_serial_select_low or negedge i_resetn) begin
    if (i_serial_select_low || !i_resetn) bits <= 5'h00;
    else bits <= next_bits;
  end

  reset_defaults_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn) $rose(i_resetn) |->
      o_active.chan_a[1] == 8'h01 && o_active.chan_b[8] == 8'h00 && !o_commit_pulse)
    else $error("active copies not at defaults");
  active_hold_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      $changed(o_active) |-> o_commit_pulse)
    else $error("active copy changed without commit");
  pulse_single_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_commit_pulse |=> !o_commit_pulse)
    else $error("commit pulse longer than one cycle");
  pulse_gap_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      $fell(o_commit_pulse) |-> !o_commit_pulse [*8])
    else $error("commit repeated too soon");
  global_clock_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_active.chan_a[1] == o_active.chan_b[1])
    else $error("global clock copies differ");
  global_divide_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_active.chan_a[3] == o_active.chan_b[3])
    else $error("global divider copies differ");
  readout_idle_a:
    assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_serial_select_low [*3] |-> o_sdio_oe_n)
    else $error("data pin driven outside frame");
  readout_start_a:
    assert property (@(negedge i_serial_clk) disable iff (!i_resetn)
      !o_sdio_oe_n |-> bits == 5'h10)
    else $error("data pin driven during instruction");

  cover property (@(posedge i_sys_clk) o_commit_pulse);
  cover property (@(posedge i_sys_clk) !o_sdio_oe_n);
  cover property (@(posedge i_sys_clk) $rose(i_resetn));
endmodule

bind sdcrb_bank sdcrb_bank_chk u_sdcrb_bank_chk (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_serial_clk(i_serial_clk),
  .i_serial_select_low(i_serial_select_low), .i_sdio(i_sdio), .o_sdio(o_sdio),
  .o_sdio_oe_n(o_sdio_oe_n), .o_active(o_active), .o_commit_pulse(o_commit_pulse));

/* sdcrb_host.sv */
/* Serial host model: one byte per frame, clock runs only in frames.
   Assumes the bench resolves the data pin from the device enable. */
module sdcrb_host (
  input  wire logic i_sdio,
  output logic      o_serial_clk,
  output logic      o_serial_select_low,
  output logic      o_sdio
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lsb_first;
  initial begin
    o_serial_clk = 1'b0;
    // Brief low at start gives the frame logic a clean reset edge
    o_serial_select_low = 1'b0;
    o_sdio = 1'b0;
    lsb_first = 1'b0;
    #0.5;
    o_serial_select_low = 1'b1;
  end

  task automatic access(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                        output logic [7:0] got);
    logic [15:0] instr;
    int k;
    instr = {rd, 2'b00, addr};
    got = 8'h00;
    #1.3;
    o_serial_select_low = 1'b0;
    for (int i = 0; i < 24; i++) begin
      k = lsb_first ? i - 16 : 23 - i;
      if (i < 16) o_sdio = instr[lsb_first ? i : 15 - i];
      else if (rd) o_sdio = ~o_sdio;
      else o_sdio = wd[k];
      #8;
      o_serial_clk = 1'b1;
      if (rd && i > 15) got[k] = i_sdio;
      #16;
      o_serial_clk = 1'b0;
      #8;
    end
    // Released line must not keep the last bit
    o_serial_select_low = 1'b1;
    o_sdio = ~o_sdio;
    #40;
  endtask
endmodule

/* testbench.sv */
/* Testbench for the shadowed register bank.
   Assumes the host model and checker are compiled first. */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary value
  localparam logic [21:0] ROWS [20] = '{
    {1'b1, 13'h000, 8'h18}, {1'b1, 13'h001, ID}, {1'b1, 13'h002, 8'h20},
    {1'b1, 13'h005, 8'h03}, {1'b1, 13'h0ff, 8'h00}, {1'b0, 13'h005, 8'h01},
    {1'b0, 13'h010, 8'h11}, {1'b0, 13'h005, 8'h02}, {1'b0, 13'h010, 8'h22},
    {1'b1, 13'h010, 8'h22}, {1'b0, 13'h009, 8'h00}, {1'b0, 13'h005, 8'h01},
    {1'b1, 13'h009, 8'h00}, {1'b0, 13'h005, 8'h03}, {1'b1, 13'h010, 8'h11},
    {1'b0, 13'h03a, 8'h5a}, {1'b0, 13'h001, 8'h77}, {1'b1, 13'h001, ID},
    {1'b1, 13'h003, 8'h00}, {1'b1, 13'h02a, 8'h00}};
  logic                      i_sys_clk = 1'b0;
  logic                      i_resetn = 1'b1;
  logic                      sclk;
  logic                      sel_n;
  logic                      host_sdio;
  logic                      o_sdio;
  logic                      o_sdio_oe_n;
  logic                      o_commit_pulse;
  logic                      sdio;
  logic [7:0]                got;
  sdcrb_pkg::sdcrb_pair_type o_active;
  int                        n_fail = 0;
  int                        n_checks = 0;
  int                        pulses = 0;

  always #2 i_sys_clk = ~i_sys_clk;
  assign sdio = o_sdio_oe_n ? host_sdio : o_sdio;
  always @(negedge i_sys_clk) if (o_commit_pulse === 1'b1) pulses++;

  sdcrb_bank #(.DEVICE_IDENTIFIER(ID), .SPEED_CODE(2'b10)) u_sdcrb_bank (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_serial_clk(sclk),
    .i_serial_select_low(sel_n), .i_sdio(sdio), .o_sdio(o_sdio),
    .o_sdio_oe_n(o_sdio_oe_n), .o_active(o_active), .o_commit_pulse(o_commit_pulse));
  sdcrb_host u_sdcrb_host (
    .i_sdio(sdio), .o_serial_clk(sclk), .o_serial_select_low(sel_n), .o_sdio(host_sdio));

  task automatic check_byte(input logic [7:0] got_v, input logic [7:0] exp_v);
    n_checks++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #1;
    i_resetn = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    for (int i = 0; i < 20; i++) begin
      u_sdcrb_host.access(ROWS[i][21], ROWS[i][20:8], ROWS[i][7:0], got);
      if (ROWS[i][21]) check_byte(got, ROWS[i][7:0]);
    end
    u_sdcrb_host.access(1'b0, 13'h005, 8'h01, got);
    u_sdcrb_host.access(1'b0, 13'h00b, 8'h2b, got);
    check_byte(o_active.chan_a[8], 8'h00);
    check_byte(o_active.chan_b[25], 8'h00);
    u_sdcrb_host.access(1'b0, 13'h0ff, 8'h01, got);
    for (int t = 0; t < 50 && pulses == 0; t++) @(negedge i_sys_clk);
    check_byte(8'(pulses), 8'h01);
    check_byte(o_active.chan_a[8], 8'h11);
    check_byte(o_active.chan_b[8], 8'h22);
    check_byte(o_active.chan_b[1], 8'h00);
    check_byte(o_active.chan_a[25], 8'h5a);
    check_byte(o_active.chan_b[25], 8'h5a);
    check_byte(o_active.chan_b[3], 8'h2b);
    u_sdcrb_host.access(1'b1, 13'h0ff, 8'h00, got);
    check_byte(got, 8'h00);
    // Only bit six set: mirroring must still switch order
    u_sdcrb_host.access(1'b0, 13'h000, 8'h40, got);
    u_sdcrb_host.lsb_first = 1'b1;
    u_sdcrb_host.access(1'b1, 13'h000, 8'h00, got);
    check_byte(got, 8'h5a);
    u_sdcrb_host.access(1'b0, 13'h000, 8'h18, got);
    u_sdcrb_host.lsb_first = 1'b0;
    u_sdcrb_host.access(1'b0, 13'h000, 8'h04, got);
    u_sdcrb_host.access(1'b1, 13'h000, 8'h00, got);
    check_byte(got, 8'h18);
    u_sdcrb_host.access(1'b1, 13'h010, 8'h00, got);
    check_byte(got, 8'h00);
    u_sdcrb_host.access(1'b0, 13'h005, 8'h01, got);
    @(negedge i_sys_clk);
    i_resetn = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    check_byte(o_active.chan_a[8], 8'h00);
    i_resetn = 1'b1;
    u_sdcrb_host.access(1'b1, 13'h005, 8'h00, got);
    check_byte(got, 8'h03);
    complete_run;
  end

  initial begin
    #100us;
    n_fail++;
    complete_run;
  end
endmodule
